// File: verilog/tomc_pkg.sv
// Constants and types for the touch output and mode controller
package tomc_pkg;
	// Clock and time base
	localparam int CLK_HZ        = 50_000_000;  // 20 ns period
	localparam int MS_PER_S      = 1000;
	localparam int MS_W          = 16;          // Width of ms counts
	// Post-release hold, buzzer, scan period and state timeout
	localparam int HOLD_STEP_MS  = 20;
	localparam int HOLD_MAX_MS   = 2000;
	localparam int BUZZ_STEP_MS  = 100;
	localparam int BUZZ_MAX_MS   = 12700;
	localparam int SCAN_STEP_MS  = 20;
	localparam int SCAN_MAX_MS   = 500;
	localparam int TOUT_MAX_S    = 63;
	localparam int BUZZ_NFREQ    = 7;
	localparam int BUZZ_HZ [BUZZ_NFREQ] =
		'{1000, 1100, 1300, 1600, 2000, 2600, 4000};
	// Target address and configuration space
	localparam logic [6:0] ADDR_MIN  = 7'h08;
	localparam logic [6:0] ADDR_MAX  = 7'h77;
	localparam logic [6:0] ADDR_RST  = 7'h37;
	localparam int         CFG_BYTES = 128;
	localparam logic [7:0] CFG_END   = 8'h80;

	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'b001,
		MODE_TOUCH  = 3'b010,
		MODE_PROX   = 3'b100
	} tomc_mode_t;

	typedef enum logic [2:0] {
		NV_RESTORE = 3'b001,
		NV_IDLE    = 3'b010,
		NV_SAVE    = 3'b100
	} tomc_nv_st_t;

	typedef struct packed {
		logic       active_high;
		logic       open_drain;
		logic       single_btn;
		logic [6:0] hold_steps;
	} tomc_out_cfg_t;

	typedef struct packed {
		logic [2:0] buzz_sel;
		logic [6:0] buzz_steps;
		logic [4:0] scan_steps;
		logic [5:0] tout_s;
		logic       prox_en;
	} tomc_sys_cfg_t;

	typedef struct packed {
		logic       we;
		logic [6:0] addr;
		logic [7:0] data;
	} tomc_byte_wr_t;

	// Steps times step size, clamped to the legal range in ms
	function automatic logic [MS_W-1:0] ms_of(input int steps,
		input int step, input int lo, input int hi);
		int v;
		v = steps * step;
		if (v < lo)
			v = lo;
		if (v > hi)
			v = hi;
		return MS_W'(v);
	endfunction
endpackage

// File: verilog/tomc_core.sv
// Touch output, buzzer, scan mode and configuration store logic
`timescale 1ns/1ps
module tomc_core
	import tomc_pkg::*;
#(
	parameter int N        = 8,       // Number of outputs
	parameter int CLK_HZ_P = CLK_HZ   // Clock rate, lower in simulation
)(
	input  wire logic          i_clk,         // Clock
	input  wire logic          i_rst_n,       // Sync reset, active low
	input  wire logic [N-1:0]  i_sense,       // Sensor status, same clock
	input  wire logic [N-1:0]  i_prox_mask,   // Sensors that are proximity
	input  wire logic [N-1:0]  i_toggle_en,   // Toggle enable per output
	input  wire logic [N-1:0]  i_hold_en,     // Hold enable per output
	input  tomc_out_cfg_t      i_out_cfg,     // Output settings
	input  tomc_sys_cfg_t      i_sys_cfg,     // Buzzer and mode settings
	input  wire logic [6:0]    i_i2c_addr,    // Requested target address
	input  tomc_byte_wr_t      i_cfg_wr,      // Host config byte write
	input  wire logic [6:0]    i_cfg_raddr,   // Host config read address
	input  wire logic          i_save_req,    // Save config, one pulse
	input  wire logic [7:0]    i_nv_rdata,    // Store read data
	output logic [N-1:0]       o_gpo_out,     // Output pin levels
	output logic [N-1:0]       o_gpo_oe_n,    // Output enables, low drives
	output logic [N-1:0]       o_status,      // Reported sensor status
	output logic               o_buzz,        // Buzzer square wave
	output tomc_mode_t         o_mode,        // Operating mode
	output logic               o_scan,        // Scan start pulse
	output logic [N-1:0]       o_scan_mask,   // Sensors to scan
	output logic [6:0]         o_target_addr, // Address answered
	output logic               o_addr_ok,     // Requested address legal
	output logic [7:0]         o_cfg_rdata,   // Host config read data
	output tomc_byte_wr_t      o_nv,          // Store address and write
	output logic               o_busy         // Restore or save running
);
	localparam int TICK_CYC = CLK_HZ_P / MS_PER_S;
	localparam int TW = $clog2(TICK_CYC);
	localparam int HW = $clog2(CLK_HZ_P / (2 * BUZZ_HZ[0]) + 1);

	// Parameter range check
	if (N < 1 || N > 8 || CLK_HZ_P < 8 * BUZZ_HZ[0])
	begin : g_bad_param
		$error("tomc_core: unsupported N or clock rate");
	end

	typedef struct packed {
		tomc_mode_t                   mode;
		tomc_nv_st_t                  nv;
		logic [TW-1:0]                tick_cnt;
		logic                         tick;
		logic [N-1:0]                 prev;
		logic [N-1:0]                 on;
		logic [N-1:0][MS_W-1:0]       hold;
		logic [N-1:0]                 status;
		logic [N-1:0]                 out;
		logic [N-1:0]                 oe_n;
		logic                         buzz_on;
		logic                         buzz;
		logic [MS_W-1:0]              buzz_ms;
		logic [HW-1:0]                half;
		logic [MS_W-1:0]              idle_ms;
		logic [MS_W-1:0]              scan_ms;
		logic                         scan;
		logic [N-1:0]                 scan_mask;
		logic [6:0]                   addr;
		logic                         addr_ok;
		logic [CFG_BYTES-1:0][7:0]    mem;
		logic [7:0]                   rdata;
		logic [7:0]                   nv_idx;
		logic                         rd1;
		logic                         rd2;
		logic [6:0]                   rd2_ptr;
		tomc_byte_wr_t                nvo;
		logic                         busy;
	} tomc_state_t;

	localparam tomc_state_t ST_RST = '{mode: MODE_ACTIVE, nv: NV_RESTORE,
		addr: ADDR_RST, oe_n: '1, busy: 1'b1, default: '0};

	tomc_state_t     st_ff;
	tomc_state_t     nxt_st;
	logic [N-1:0]    stat;
	logic [N-1:0]    seen;
	logic            lock;
	logic            touch;
	logic [MS_W-1:0] hold_ms;
	logic [MS_W-1:0] buzz_tgt;
	logic [MS_W-1:0] scan_tgt;
	logic [MS_W-1:0] tout_tgt;

	// Buzzer half period in clock cycles
	function automatic logic [HW-1:0] half_of(input logic [2:0] sel);
		int f;
		f = BUZZ_HZ[(int'(sel) < BUZZ_NFREQ) ? int'(sel) : 0];
		return HW'(CLK_HZ_P / (2 * f));
	endfunction

	// Keep only the lowest set bit
	function automatic logic [N-1:0] lowest(input logic [N-1:0] x);
		return x & (~x + 1'b1);
	endfunction

	// Timer targets and shared conditions
	assign hold_ms  = ms_of(int'(i_out_cfg.hold_steps), HOLD_STEP_MS,
		0, HOLD_MAX_MS);
	assign buzz_tgt = ms_of(int'(i_sys_cfg.buzz_steps), BUZZ_STEP_MS,
		BUZZ_STEP_MS, BUZZ_MAX_MS);
	assign scan_tgt = ms_of(int'(i_sys_cfg.scan_steps), SCAN_STEP_MS,
		SCAN_STEP_MS, SCAN_MAX_MS);
	assign tout_tgt = ms_of(int'(i_sys_cfg.tout_s), MS_PER_S,
		0, TOUT_MAX_S * MS_PER_S);
	assign stat  = i_out_cfg.single_btn ? lowest(i_sense) : i_sense;
	assign lock  = |(i_toggle_en & st_ff.on);
	assign seen  = (st_ff.mode == MODE_PROX) ? (stat & i_prox_mask) : stat;
	assign touch = |seen;

	// Next state
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		nxt_st.scan = 1'b0;
		nxt_st.rd1 = 1'b0;
		nxt_st.nvo.we = 1'b0;
		// Millisecond tick
		if (st_ff.tick_cnt == TW'(TICK_CYC - 1))
		begin
			nxt_st.tick_cnt = '0;
			nxt_st.tick = 1'b1;
		end
		else
			nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
		nxt_st.status = stat;
		nxt_st.prev = stat;
		// Per-output toggle, hold or follow
		for (int i = 0; i < N; i++)
		begin
			if (i_toggle_en[i])
			begin
				if (stat[i] && !st_ff.prev[i])
					nxt_st.on[i] = !st_ff.on[i];
			end
			else if (i_hold_en[i])
			begin
				if (stat[i])
				begin
					nxt_st.on[i] = 1'b1;
					nxt_st.hold[i] = hold_ms;
				end
				else if (st_ff.hold[i] == '0)
					nxt_st.on[i] = 1'b0;
				else if (st_ff.tick)
					nxt_st.hold[i] = st_ff.hold[i] - 1'b1;
			end
			else
				nxt_st.on[i] = stat[i];
			if (i_out_cfg.open_drain)
			begin
				nxt_st.out[i] = 1'b0;
				nxt_st.oe_n[i] = !nxt_st.on[i];
			end
			else
			begin
				nxt_st.out[i] = nxt_st.on[i] ~^ i_out_cfg.active_high;
				nxt_st.oe_n[i] = 1'b0;
			end
		end
		// Buzzer: fixed on-time, no retrigger, half period toggling
		if (st_ff.buzz_on)
		begin
			if (st_ff.tick && st_ff.buzz_ms <= MS_W'(1))
			begin
				nxt_st.buzz_on = 1'b0;
				nxt_st.buzz = 1'b0;
			end
			else
			begin
				if (st_ff.tick)
					nxt_st.buzz_ms = st_ff.buzz_ms - 1'b1;
				if (st_ff.half == '0)
				begin
					nxt_st.buzz = !st_ff.buzz;
					nxt_st.half = half_of(i_sys_cfg.buzz_sel) - 1'b1;
				end
				else
					nxt_st.half = st_ff.half - 1'b1;
			end
		end
		else if (|(stat & ~st_ff.prev))
		begin
			nxt_st.buzz_on = 1'b1;
			nxt_st.buzz = 1'b1;
			nxt_st.buzz_ms = buzz_tgt;
			nxt_st.half = half_of(i_sys_cfg.buzz_sel) - 1'b1;
		end
		// Operating mode sequencing
		unique case (st_ff.mode)
			MODE_ACTIVE:
				if (touch)
					nxt_st.idle_ms = '0;
				else if (st_ff.idle_ms >= tout_tgt)
				begin
					nxt_st.mode = MODE_TOUCH;
					nxt_st.idle_ms = '0;
				end
				else if (st_ff.tick)
					nxt_st.idle_ms = st_ff.idle_ms + 1'b1;
			MODE_TOUCH:
				if (touch)
				begin
					nxt_st.mode = MODE_ACTIVE;
					nxt_st.idle_ms = '0;
				end
				else if (st_ff.idle_ms >= tout_tgt)
				begin
					nxt_st.idle_ms = '0;
					if (i_sys_cfg.prox_en && |i_prox_mask && !lock)
						nxt_st.mode = MODE_PROX;
				end
				else if (st_ff.tick)
					nxt_st.idle_ms = st_ff.idle_ms + 1'b1;
			MODE_PROX:
				if (touch)
					nxt_st.mode = MODE_TOUCH;
		endcase
		// Scan pacing: every tick when active, else every scan period
		if (st_ff.mode == MODE_ACTIVE)
		begin
			nxt_st.scan = st_ff.tick;
			nxt_st.scan_ms = '0;
		end
		else if (st_ff.tick)
		begin
			if (st_ff.scan_ms + 1'b1 >= scan_tgt)
			begin
				nxt_st.scan = 1'b1;
				nxt_st.scan_ms = '0;
			end
			else
				nxt_st.scan_ms = st_ff.scan_ms + 1'b1;
		end
		nxt_st.scan_mask = (nxt_st.mode == MODE_PROX) ? i_prox_mask : '1;
		// Target address, kept when the request is out of range
		nxt_st.addr_ok = (i_i2c_addr >= ADDR_MIN) && (i_i2c_addr <= ADDR_MAX);
		if (nxt_st.addr_ok)
			nxt_st.addr = i_i2c_addr;
		// Configuration store and nonvolatile copy
		nxt_st.rdata = st_ff.mem[i_cfg_raddr];
		if (st_ff.rd2)
			nxt_st.mem[st_ff.rd2_ptr] = i_nv_rdata;
		nxt_st.rd2 = st_ff.rd1;
		nxt_st.rd2_ptr = st_ff.nvo.addr;
		unique case (st_ff.nv)
			NV_RESTORE:
				if (st_ff.nv_idx != CFG_END)
				begin
					nxt_st.nvo.addr = st_ff.nv_idx[6:0];
					nxt_st.rd1 = 1'b1;
					nxt_st.nv_idx = st_ff.nv_idx + 1'b1;
				end
				else if (!st_ff.rd1 && !st_ff.rd2)
				begin
					nxt_st.nv = NV_IDLE;
					nxt_st.nv_idx = '0;
				end
			NV_IDLE:
				if (i_save_req)
					nxt_st.nv = NV_SAVE;
				else if (i_cfg_wr.we)
					nxt_st.mem[i_cfg_wr.addr] = i_cfg_wr.data;
			NV_SAVE:
				if (st_ff.nv_idx != CFG_END)
				begin
					nxt_st.nvo.we = 1'b1;
					nxt_st.nvo.addr = st_ff.nv_idx[6:0];
					nxt_st.nvo.data = st_ff.mem[st_ff.nv_idx[6:0]];
					nxt_st.nv_idx = st_ff.nv_idx + 1'b1;
				end
				else
				begin
					nxt_st.nv = NV_IDLE;
					nxt_st.nv_idx = '0;
				end
		endcase
		nxt_st.busy = (nxt_st.nv != NV_IDLE);           // Busy kept as a flop
	end

	// State register
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	// Outputs straight from the state register
	assign o_gpo_out     = st_ff.out;
	assign o_gpo_oe_n    = st_ff.oe_n;
	assign o_status      = st_ff.status;
	assign o_buzz        = st_ff.buzz;
	assign o_mode        = st_ff.mode;
	assign o_scan        = st_ff.scan;
	assign o_scan_mask   = st_ff.scan_mask;
	assign o_target_addr = st_ff.addr;
	assign o_addr_ok     = st_ff.addr_ok;
	assign o_cfg_rdata   = st_ff.rdata;
	assign o_nv          = st_ff.nvo;
	assign o_busy        = st_ff.busy;

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_plain_follow: assert property ($past(i_rst_n) &&
		$past(!i_toggle_en[0] && !i_hold_en[0]) |-> st_ff.on[0] == $past(stat[0]))
		else $error("plain output not following sensor");
	chk_polarity_level: assert property ($past(i_rst_n) &&
		$past(!i_out_cfg.open_drain) |->
		st_ff.out[0] == (st_ff.on[0] == $past(i_out_cfg.active_high)))
		else $error("output level ignores polarity");
	chk_toggle_fall: assert property (i_toggle_en[0] &&
		st_ff.prev[0] && !stat[0] |=> $stable(st_ff.on[0]))
		else $error("toggle output changed on falling edge");
	chk_hold_keeps: assert property (i_hold_en[0] &&
		!i_toggle_en[0] && st_ff.on[0] && !stat[0] && st_ff.hold[0] > 1
		|=> st_ff.on[0])
		else $error("held output dropped early");
	chk_od_drive: assert property ($past(i_rst_n) &&
		$past(i_out_cfg.open_drain) |->
		st_ff.out == '0 && st_ff.oe_n == ~st_ff.on)
		else $error("open-drain drive wrong");
	chk_single_btn: assert property ($past(i_rst_n) &&
		$past(i_out_cfg.single_btn) |-> $onehot0(st_ff.status))
		else $error("more than one button reported");
	chk_buzz_ends: assert property (st_ff.buzz_on &&
		st_ff.tick && st_ff.buzz_ms <= 1 |=> !st_ff.buzz_on ##0 !st_ff.buzz)
		else $error("buzzer did not stop at on-time");
	chk_no_retrigger: assert property (st_ff.buzz_on &&
		!(st_ff.tick && st_ff.buzz_ms <= 1) |=> st_ff.buzz_on &&
		st_ff.buzz_ms == $past(st_ff.buzz_ms) - MS_W'($past(st_ff.tick)))
		else $error("buzzer on-time restarted");
	chk_prox_entry: assert property ($rose(st_ff.mode == MODE_PROX)
		|-> $past(!lock && i_sys_cfg.prox_en))
		else $error("proximity mode entered while blocked");
	chk_prox_wake: assert property (st_ff.mode == MODE_PROX &&
		|(stat & i_prox_mask) |=> st_ff.mode == MODE_TOUCH)
		else $error("proximity did not wake to touch mode");
	chk_addr_range: assert property ($past(i_rst_n) &&
		$past(i_i2c_addr < ADDR_MIN || i_i2c_addr > ADDR_MAX) |->
		!st_ff.addr_ok && $stable(st_ff.addr))
		else $error("illegal target address accepted");
endmodule // tomc_core

// File: sim/tomc_nv_model.sv
// Nonvolatile store model facing the configuration save and restore
`timescale 1ns/1ps
module tomc_nv_model
	import tomc_pkg::*;
(
	input  wire logic    i_clk,   // Clock
	input  tomc_byte_wr_t i_nv,   // Address and write strobe
	output logic [7:0]   o_rdata  // Read data, one cycle late
);
	logic [7:0] mem [CFG_BYTES];

	// Erased store reads all ones
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'hff;
	end

	// Keep saved bytes, answer reads one cycle after the address
	always @(posedge i_clk)
	begin
		if (i_nv.we === 1'b1)
			mem[i_nv.addr] <= i_nv.data;
		o_rdata <= mem[i_nv.addr];
	end
endmodule // tomc_nv_model

// File: sim/tomc_core_test.sv
// Self-checking bench for the touch output and mode controller
`timescale 1ns/1ps
module tomc_core_test
	import tomc_pkg::*;
;
	localparam int HZ = 100000; // One ms tick is 100 cycles
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic [7:0]    sense = 8'h00;
	logic [7:0]    pm = 8'h00;
	logic [7:0]    ten = 8'h00;
	logic [7:0]    hen = 8'h00;
	tomc_out_cfg_t oc = '{1'b1, 1'b0, 1'b0, 7'h01};
	tomc_sys_cfg_t sc = '{3'h0, 7'h01, 5'h01, 6'h00, 1'b0};
	logic [6:0]    ad = 7'h37;
	logic [6:0]    ra = 7'h00;
	tomc_byte_wr_t wr = '0;
	logic          sv = 1'b0;
	logic [7:0]    nvr;
	logic [7:0]    out, oe_n, st, smask, rd;
	logic          buzz, scan, ok, busy;
	logic [6:0]    tgt;
	tomc_mode_t    mode;
	tomc_byte_wr_t nv;
	int            n_mismatch = 0;
	int            checked = 0;
	int            cycles = 0;

	tomc_core #(.CLK_HZ_P(HZ)) uut (.i_clk(clk), .i_rst_n(rst_n),
		.i_sense(sense), .i_prox_mask(pm), .i_toggle_en(ten),
		.i_hold_en(hen), .i_out_cfg(oc), .i_sys_cfg(sc), .i_i2c_addr(ad),
		.i_cfg_wr(wr), .i_cfg_raddr(ra), .i_save_req(sv),
		.i_nv_rdata(nvr), .o_gpo_out(out), .o_gpo_oe_n(oe_n),
		.o_status(st), .o_buzz(buzz), .o_mode(mode), .o_scan(scan),
		.o_scan_mask(smask), .o_target_addr(tgt), .o_addr_ok(ok),
		.o_cfg_rdata(rd), .o_nv(nv), .o_busy(busy));
	tomc_nv_model nvm (.i_clk(clk), .i_nv(nv), .o_rdata(nvr));

	// Clock, and a ceiling on the whole run
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Cycles the buzzer stays at one level, up to 200
	task automatic run_len(input logic v, output int n);
		n = 0;
		while (buzz === v && n < 200)
		begin
			n++;
			cyc(1);
		end
	endtask

	// Cycles until the next scan pulse
	task automatic wscan(output int n);
		n = 0;
		do
		begin
			n++;
			cyc(1);
		end while (scan !== 1'b1 && n < 3000);
	endtask

	task automatic t_reset();
		int n;
		rst_n = 1'b0;
		cyc(10);
		chk("oe_n", 8'hff, oe_n);
		chk("out", 8'h00, out);
		chk("buzz", 0, buzz);
		chk("addr_rst", ADDR_RST, tgt);
		rst_n = 1'b1;
		n = 0;
		while (busy !== 1'b0 && n < 400)
		begin
			n++;
			cyc(1);
		end
		chk("busy", 0, busy);
	endtask

	task automatic t_plain();
		sense = 8'h01;
		cyc(2);
		chk("out_hi", 8'h01, out);
		chk("oe_strong", 0, oe_n[0]);
		oc.active_high = 1'b0;
		cyc(2);
		chk("out_lo", 8'hfe, out);
		oc.open_drain = 1'b1;
		cyc(2);
		chk("oe_od", 8'hfe, oe_n);
		chk("od_low", 0, out[0]);
		sense = 8'h00;
		cyc(2);
		chk("oe_rel", 8'hff, oe_n);
		oc = '{1'b1, 1'b0, 1'b1, 7'h01};
		sense = 8'h06;
		cyc(3);
		chk("single", 8'h02, st);
		oc.single_btn = 1'b0;
		sense = 8'h00;
		cyc(3);
	endtask

	task automatic t_toggle();
		ten = 8'h02;
		hen = 8'h02;
		sense = 8'h03;
		cyc(3);
		chk("tg_on", 8'h03, out);
		sense = 8'h00;
		cyc(3);
		chk("tg_fall", 8'h02, out);
		sense = 8'h02;
		cyc(3);
		chk("tg_off", 0, out[1]);
		sense = 8'h00;
		cyc(3);
		ten = 8'h00;
		hen = 8'h00;
	endtask

	task automatic t_hold();
		hen = 8'h01;
		sense = 8'h03;
		cyc(3);
		sense = 8'h00;
		cyc(2);
		chk("hold_none", 0, out[1]);
		cyc(1885);
		chk("hold_on", 1, out[0]);
		cyc(120);
		chk("hold_end", 0, out[0]);
		hen = 8'h00;
	endtask

	task automatic t_addr(input logic [6:0] a, input logic k,
		input logic [6:0] t);
		ad = a;
		cyc(2);
		chk("addr_ok", k, ok);
		chk("addr", t, tgt);
	endtask

	task automatic wbyte(input logic [6:0] a, input logic [7:0] d);
		wr = '{1'b1, a, d};
		cyc(1);
	endtask

	task automatic rbyte(input logic [6:0] a, input logic [7:0] d);
		ra = a;
		cyc(2);
		chk("cfg_rd", d, rd);
	endtask

	task automatic t_cfg();
		int n;
		wbyte(7'h7e, 8'ha5);
		wbyte(7'h00, 8'h5a);
		wr.we = 1'b0;
		rbyte(7'h7e, 8'ha5);
		rbyte(7'h00, 8'h5a);
		sv = 1'b1;
		cyc(1);
		sv = 1'b0;
		n = 0;
		repeat (140)
		begin
			cyc(1);
			if (nv.we === 1'b1)
				n++;
		end
		chk("nv_bytes", 16'd128, 16'(n));
		t_reset();
		rbyte(7'h7e, 8'ha5);
		rbyte(7'h00, 8'h5a);
	endtask

	task automatic t_buzz();
		int n;
		sense = 8'h08;
		cyc(2);
		chk("bz_start", 1, buzz);
		run_len(1'b1, n);
		run_len(1'b0, n);
		chk("bz_low", 50, 16'(n));
		run_len(1'b1, n);
		chk("bz_high", 50, 16'(n));
		// Highest tone: half period from the fastest frequency
		sc.buzz_sel = 3'h6;
		run_len(1'b0, n);
		run_len(1'b1, n);
		chk("bz_fast", 16'(HZ / (2 * BUZZ_HZ[6])), 16'(n));
		sc.buzz_sel = 3'h0;
		cyc(4000);
		sense = 8'h18;
		cyc(5500);
		run_len(buzz, n);
		run_len(buzz, n);
		chk("bz_late", 50, 16'(n));
		cyc(300);
		run_len(1'b0, n);
		chk("bz_idle", 200, 16'(n));
		sense = 8'h00;
		cyc(3);
	endtask

	task automatic t_mode();
		int n;
		pm = 8'h80;
		cyc(5);
		chk("mode_t", MODE_TOUCH, mode);
		chk("scan_all", 8'hff, smask);
		cyc(200);
		chk("mode_np", MODE_TOUCH, mode);
		wscan(n);
		wscan(n);
		chk("scan_gap_t", 2000, 16'(n));
		ten = 8'h01;
		sc.prox_en = 1'b1;
		sense = 8'h01;
		cyc(3);
		chk("mode_a", MODE_ACTIVE, mode);
		sense = 8'h00;
		cyc(200);
		chk("mode_tg", MODE_TOUCH, mode);
		sense = 8'h01;
		cyc(3);
		sense = 8'h00;
		cyc(5);
		chk("mode_p", MODE_PROX, mode);
		chk("scan_px", 8'h80, smask);
		wscan(n);
		wscan(n);
		chk("scan_gap_p", 2000, 16'(n));
		sc.tout_s = 6'h01;
		sense = 8'h02;
		cyc(3);
		chk("mode_pk", MODE_PROX, mode);
		sense = 8'h80;
		cyc(1);
		sense = 8'h00;
		cyc(4);
		chk("mode_w", MODE_TOUCH, mode);
		ten = 8'h00;
	endtask

	// Main sequence
	initial
	begin
		t_reset();
		t_plain();
		t_toggle();
		t_hold();
		t_addr(7'h77, 1'b1, 7'h77);
		t_addr(7'h78, 1'b0, 7'h77);
		t_addr(7'h07, 1'b0, 7'h77);
		t_addr(7'h08, 1'b1, 7'h08);
		t_cfg();
		t_buzz();
		t_mode();
		test_done();
	end
endmodule // tomc_core_test
